// ---- rtl/rri_pkg.sv ----
package rri_pkg;

    // register offsets (printed offsets are not multiples of four: index, byte = 4 * index)
    localparam logic [7:0] IDX_INDIRECT_WINDOW = 8'h00;
    localparam logic [7:0] IDX_TIMER_COUNT     = 8'h01;
    localparam logic [7:0] IDX_PC_LOW          = 8'h02;
    localparam logic [7:0] IDX_CORE_STATUS     = 8'h03;
    localparam logic [7:0] IDX_INDIRECT_PTR    = 8'h04;
    localparam logic [7:0] IDX_PORT1_DATA      = 8'h05;
    localparam logic [7:0] IDX_PORT2_DATA      = 8'h06;
    localparam logic [7:0] IDX_PC_HIGH_LATCH   = 8'h0A;
    localparam logic [7:0] IDX_INT_CONTROL     = 8'h0B;
    localparam logic [7:0] IDX_PERIPH_FLAGS    = 8'h0C;
    localparam logic [7:0] IDX_CMP_CONTROL     = 8'h1F;
    localparam logic [7:0] IDX_OPTION_CONFIG   = 8'h81;
    localparam logic [7:0] IDX_PORT1_DIR       = 8'h85;
    localparam logic [7:0] IDX_PORT2_DIR       = 8'h86;
    localparam logic [7:0] IDX_PERIPH_ENABLES  = 8'h8C;
    localparam logic [7:0] IDX_POWER_FLAGS     = 8'h8E;
    localparam logic [7:0] IDX_VREF_CONTROL    = 8'h9F;
    localparam logic [7:0] IDX_WORKING_ACC     = 8'hF0;
    localparam logic [7:0] IDX_PC_HIGH         = 8'hF1;

    // reset and wake values
    localparam logic [7:0] PC_LOW_RESET     = 8'h00;
    localparam logic [12:0] PC_IRQ_VECTOR   = 13'h0004;
    localparam logic [7:0] OPTION_RESET     = 8'hFF;
    localparam logic [4:0] PORT1_DIR_RESET  = 5'h1F;
    localparam logic [7:0] PORT2_DIR_RESET  = 8'hFF;
    localparam logic [5:0] CMP_RESET        = 6'h00;
    localparam logic [4:0] PROGRAM_COUNTER_HIGH_LATCH_RESET     = 5'h00;
    localparam logic [7:0] VREF_RESET       = 8'h00;
    localparam logic [7:0] VREF_IMPL_MASK   = 8'hEF;
    localparam logic [7:0] STATUS_POR_UPPER = 8'h18;

    // field positions
    localparam int STATUS_TO_BIT   = 4;
    localparam int STATUS_PD_BIT   = 3;
    localparam int GIE_BIT         = 7;
    localparam int CMP_FLAG_BIT    = 6;
    localparam int BROWN_OUT_BIT   = 0;
    localparam int POWER_ON_BIT    = 1;

    typedef enum logic [3:0] {
        EV_NONE       = 4'h0,
        EV_POWER_ON   = 4'h1,
        EV_MASTER_CLEAR_INPUT_RUN   = 4'h2,
        EV_MASTER_CLEAR_INPUT_SLEEP = 4'h3,
        EV_WDT_RESET  = 4'h4,
        EV_BROWN_OUT  = 4'h5,
        EV_WAKE_WDT   = 4'h6,
        EV_WAKE_IRQ   = 4'h7
    } rri_event_t;

    // wake-up interrupt sources
    typedef struct packed {
        logic ext_pin;
        logic timer;
        logic port_change;
        logic comparator;
    } rri_wake_src_t;

    typedef struct packed {
        rri_event_t    kind;
        rri_wake_src_t src;
    } rri_cause_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } rri_apb_req_t;

endpackage : rri_pkg

// ---- rtl/rri_reset_register_init.sv ----
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module rri_reset_register_init
    import rri_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // reset cause from sequencer
    input  wire rri_cause_t  cause_i,
    input  wire logic        supply_low_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // state to core
    output logic [12:0]      pc_o,
    output logic             gie_o,
    output logic [7:0]       option_o,
    output logic [12:0]      port_dir_o
);

    logic [7:0]  w_reg, w_next, tmr_reg, tmr_next, fsr_reg, fsr_next;
    logic [4:0]  pa_reg, pa_next;
    logic [7:0]  pb_reg, pb_next;
    logic [12:0] pc_reg, pc_next;
    logic [4:0]  program_counter_high_latch_reg, program_counter_high_latch_next;
    logic [7:0]  status_reg, status_next, interrupt_control_reg, interrupt_control_next;
    logic        cmif_reg, cmif_next, cmie_reg, cmie_next;
    logic [5:0]  comparator_control_reg, comparator_control_next;
    logic [7:0]  option_reg, option_next, second_port_direction_reg, second_port_direction_next, voltage_reference_control_reg, voltage_reference_control_next;
    logic [4:0]  first_port_direction_reg, first_port_direction_next;
    logic [1:0]  power_control_flags_reg, power_control_flags_next;
    logic [31:0] prdata_reg, prdata_next;
    logic        pready_reg, pready_next, pslverr_reg, pslverr_next;
    rri_event_t  ev;
    logic        wr_en, rd_en, any_reset, mapped;
    logic [7:0]  idx, wd;

    function automatic logic is_mapped(input logic [7:0] i);
        is_mapped = (i == IDX_INDIRECT_WINDOW) || (i == IDX_TIMER_COUNT) || (i == IDX_PC_LOW)
            || (i == IDX_CORE_STATUS) || (i == IDX_INDIRECT_PTR) || (i == IDX_PORT1_DATA)
            || (i == IDX_PORT2_DATA) || (i == IDX_PC_HIGH_LATCH) || (i == IDX_INT_CONTROL)
            || (i == IDX_PERIPH_FLAGS) || (i == IDX_CMP_CONTROL) || (i == IDX_OPTION_CONFIG)
            || (i == IDX_PORT1_DIR) || (i == IDX_PORT2_DIR) || (i == IDX_PERIPH_ENABLES)
            || (i == IDX_POWER_FLAGS) || (i == IDX_VREF_CONTROL) || (i == IDX_WORKING_ACC)
            || (i == IDX_PC_HIGH);
    endfunction : is_mapped

    // supply collapse forces power-on values
    assign ev = supply_low_i ? EV_POWER_ON : cause_i.kind;
    assign any_reset = (ev == EV_POWER_ON) || (ev == EV_MASTER_CLEAR_INPUT_RUN) || (ev == EV_MASTER_CLEAR_INPUT_SLEEP)
                    || (ev == EV_WDT_RESET) || (ev == EV_BROWN_OUT);
    assign idx    = paddr_i[9:2];
    assign wd     = pwdata_i[7:0];
    assign mapped = (paddr_i[1:0] == 2'b00) && (paddr_i[11:10] == 2'b00) && is_mapped(idx);
    // a write lands only at the edge where ready is seen high
    assign wr_en  = psel_i && penable_i && pwrite_i && mapped && pready_reg;
    assign rd_en  = psel_i && !penable_i && !pwrite_i;

    always_comb
    begin
        w_next      = w_reg;
        tmr_next    = tmr_reg;
        fsr_next    = fsr_reg;
        pa_next     = pa_reg;
        pb_next     = pb_reg;
        pc_next     = pc_reg;
        program_counter_high_latch_next = program_counter_high_latch_reg;
        status_next = status_reg;
        interrupt_control_next = interrupt_control_reg;
        cmif_next   = cmif_reg;
        cmie_next   = cmie_reg;
        comparator_control_next  = comparator_control_reg;
        option_next = option_reg;
        first_port_direction_next  = first_port_direction_reg;
        second_port_direction_next  = second_port_direction_reg;
        voltage_reference_control_next  = voltage_reference_control_reg;
        power_control_flags_next   = power_control_flags_reg;
        // software writes first; reset or wake events override below
        if (wr_en)
        begin
            if (idx == IDX_WORKING_ACC)
                w_next = wd;
            else if (idx == IDX_TIMER_COUNT)
                tmr_next = wd;
            else if (idx == IDX_PC_LOW)
                pc_next = {program_counter_high_latch_reg, wd};
            else if (idx == IDX_CORE_STATUS)
                status_next = {wd[7:5], status_reg[STATUS_TO_BIT:STATUS_PD_BIT], wd[2:0]};
            else if (idx == IDX_INDIRECT_PTR)
                fsr_next = wd;
            else if (idx == IDX_PORT1_DATA)
                pa_next = wd[4:0];
            else if (idx == IDX_PORT2_DATA)
                pb_next = wd;
            else if (idx == IDX_PC_HIGH_LATCH)
                program_counter_high_latch_next = wd[4:0];
            else if (idx == IDX_INT_CONTROL)
                interrupt_control_next = wd;
            else if (idx == IDX_PERIPH_FLAGS)
                cmif_next = wd[CMP_FLAG_BIT];
            else if (idx == IDX_CMP_CONTROL)
                comparator_control_next = wd[5:0];
            else if (idx == IDX_OPTION_CONFIG)
                option_next = wd;
            else if (idx == IDX_PORT1_DIR)
                first_port_direction_next = wd[4:0];
            else if (idx == IDX_PORT2_DIR)
                second_port_direction_next = wd;
            else if (idx == IDX_PERIPH_ENABLES)
                cmie_next = wd[CMP_FLAG_BIT];
            else if (idx == IDX_POWER_FLAGS)
                power_control_flags_next = wd[1:0];
            else if (idx == IDX_VREF_CONTROL)
                voltage_reference_control_next = wd & VREF_IMPL_MASK;
        end
        if (any_reset)
        begin
            // working, timer, pointer and port data untouched
            pc_next     = {PROGRAM_COUNTER_HIGH_LATCH_RESET, PC_LOW_RESET};
            program_counter_high_latch_next = PROGRAM_COUNTER_HIGH_LATCH_RESET;
            option_next = OPTION_RESET;
            first_port_direction_next  = PORT1_DIR_RESET;
            second_port_direction_next  = PORT2_DIR_RESET;
            comparator_control_next  = CMP_RESET;
            voltage_reference_control_next  = VREF_RESET;
            cmie_next   = 1'b0;
            cmif_next   = 1'b0;
            interrupt_control_next = {7'h00, interrupt_control_reg[0]};
            status_next[7:5] = 3'h0;
        end
        case (ev)
            EV_POWER_ON:
            begin
                status_next = {STATUS_POR_UPPER[7:3], status_reg[2:0]};
                power_control_flags_next[POWER_ON_BIT] = 1'b0;
            end
            EV_MASTER_CLEAR_INPUT_SLEEP:
            begin
                status_next[STATUS_TO_BIT] = 1'b1;
                status_next[STATUS_PD_BIT] = 1'b0;
            end
            EV_WDT_RESET:
                status_next[STATUS_TO_BIT] = 1'b0;
            EV_BROWN_OUT:
                power_control_flags_next[BROWN_OUT_BIT] = 1'b0;
            EV_WAKE_WDT:
            begin
                pc_next = pc_reg + 13'h0001;
                status_next[STATUS_TO_BIT] = 1'b0;
                status_next[STATUS_PD_BIT] = 1'b0;
            end
            EV_WAKE_IRQ:
            begin
                status_next[STATUS_TO_BIT] = 1'b1;
                status_next[STATUS_PD_BIT] = 1'b0;
                // cause flags set, winning over a same-cycle write
                interrupt_control_next[1] = interrupt_control_next[1] | cause_i.src.ext_pin;
                interrupt_control_next[2] = interrupt_control_next[2] | cause_i.src.timer;
                interrupt_control_next[0] = interrupt_control_next[0] | cause_i.src.port_change;
                cmif_next      = cmif_next | cause_i.src.comparator;
                if (interrupt_control_reg[GIE_BIT])
                    pc_next = PC_IRQ_VECTOR;
                else
                    pc_next = pc_reg + 13'h0001;
            end
            default:
            begin
            end
        endcase
    end

    always_comb
    begin
        prdata_next  = 32'h0000_0000;
        pready_next  = 1'b0;
        pslverr_next = 1'b0;
        if (psel_i && penable_i && !pready_reg)
        begin
            pready_next  = 1'b1;
            pslverr_next = !mapped;
            prdata_next  = prdata_reg;
        end
        else if (rd_en && mapped)
        begin
            if (idx == IDX_WORKING_ACC)
                prdata_next[7:0] = w_reg;
            else if (idx == IDX_TIMER_COUNT)
                prdata_next[7:0] = tmr_reg;
            else if (idx == IDX_PC_LOW)
                prdata_next[7:0] = pc_reg[7:0];
            else if (idx == IDX_CORE_STATUS)
                prdata_next[7:0] = status_reg;
            else if (idx == IDX_INDIRECT_PTR)
                prdata_next[7:0] = fsr_reg;
            else if (idx == IDX_PORT1_DATA)
                prdata_next[4:0] = pa_reg;
            else if (idx == IDX_PORT2_DATA)
                prdata_next[7:0] = pb_reg;
            else if (idx == IDX_PC_HIGH_LATCH)
                prdata_next[4:0] = program_counter_high_latch_reg;
            else if (idx == IDX_INT_CONTROL)
                prdata_next[7:0] = interrupt_control_reg;
            else if (idx == IDX_PERIPH_FLAGS)
                prdata_next[CMP_FLAG_BIT] = cmif_reg;
            else if (idx == IDX_CMP_CONTROL)
                prdata_next[5:0] = comparator_control_reg;
            else if (idx == IDX_OPTION_CONFIG)
                prdata_next[7:0] = option_reg;
            else if (idx == IDX_PORT1_DIR)
                prdata_next[4:0] = first_port_direction_reg;
            else if (idx == IDX_PORT2_DIR)
                prdata_next[7:0] = second_port_direction_reg;
            else if (idx == IDX_PERIPH_ENABLES)
                prdata_next[CMP_FLAG_BIT] = cmie_reg;
            else if (idx == IDX_POWER_FLAGS)
                prdata_next[1:0] = power_control_flags_reg;
            else if (idx == IDX_VREF_CONTROL)
                prdata_next[7:0] = voltage_reference_control_reg & VREF_IMPL_MASK;
            else if (idx == IDX_PC_HIGH)
                prdata_next[4:0] = pc_reg[12:8];
        end
    end

    // architectural state is kept by events, not by the bus reset
    always_ff @(posedge clk_i)
    begin
        w_reg      <= w_next;
        tmr_reg    <= tmr_next;
        fsr_reg    <= fsr_next;
        pa_reg     <= pa_next;
        pb_reg     <= pb_next;
        pc_reg     <= pc_next;
        program_counter_high_latch_reg <= program_counter_high_latch_next;
        status_reg <= status_next;
        interrupt_control_reg <= interrupt_control_next;
        cmif_reg   <= cmif_next;
        cmie_reg   <= cmie_next;
        comparator_control_reg  <= comparator_control_next;
        option_reg <= option_next;
        first_port_direction_reg  <= first_port_direction_next;
        second_port_direction_reg  <= second_port_direction_next;
        voltage_reference_control_reg  <= voltage_reference_control_next;
        power_control_flags_reg   <= power_control_flags_next;
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            pc_o        <= 13'h0000;
            gie_o       <= 1'b0;
            option_o    <= OPTION_RESET;
            port_dir_o  <= {PORT2_DIR_RESET, PORT1_DIR_RESET};
        end
        else
        begin
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
            pc_o        <= pc_next;
            gie_o       <= interrupt_control_next[GIE_BIT];
            option_o    <= option_next;
            port_dir_o  <= {second_port_direction_next, first_port_direction_next};
        end
    end

    assign prdata_o  = prdata_reg;
    assign pready_o  = pready_reg;
    assign pslverr_o = pslverr_reg;

endmodule : rri_reset_register_init

`default_nettype wire

// ---- test/rri_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module rri_checker
    import rri_pkg::*;
(
    // clock and reset
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    // cause
    input wire rri_cause_t  cause_i,
    input wire logic        supply_low_i,
    // apb
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // core state
    input wire logic [12:0] pc_o,
    input wire logic        gie_o,
    input wire logic [7:0]  option_o,
    input wire logic [12:0] port_dir_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    wire logic rst_ev = supply_low_i
        || (cause_i.kind >= EV_POWER_ON && cause_i.kind <= EV_BROWN_OUT);
    wire logic wake = !supply_low_i && !psel_i
        && (cause_i.kind == EV_WAKE_WDT || cause_i.kind == EV_WAKE_IRQ);
    wire logic bad = paddr_i[1:0] != 2'b00 || paddr_i[11:10] != 2'b00;
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_first;
        s_setup ##1 psel_i && penable_i && !pready_o;
    endsequence
    a_opt_ones: assert property (rst_ev |=> option_o == 8'hFF)
        else $error("option not all ones");
    a_dir_ones: assert property (rst_ev |=> port_dir_o == 13'h1FFF)
        else $error("directions not all inputs");
    a_pc_clear: assert property (rst_ev |=> pc_o == 13'h0000)
        else $error("pc not cleared");
    a_gie_clear: assert property (rst_ev |=> !gie_o)
        else $error("global enable not cleared");
    a_wake_keep: assert property (wake |=> $stable(option_o) && $stable(port_dir_o))
        else $error("wake changed option or directions");
    a_pc_step: assert property (wake && cause_i.kind == EV_WAKE_WDT
        |=> pc_o == $past(pc_o) + 13'd1) else $error("pc not advanced");
    a_irq_step: assert property (wake && cause_i.kind == EV_WAKE_IRQ && !gie_o
        |=> pc_o == $past(pc_o) + 13'd1) else $error("pc not advanced");
    a_pc_vector: assert property (wake && cause_i.kind == EV_WAKE_IRQ && gie_o
        |=> pc_o == 13'h0004) else $error("pc not at vector");
    a_ready_slot: assert property (s_first |=> pready_o)
        else $error("ready late");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready held");
    a_bad_addr: assert property (s_setup ##1 psel_i && penable_i && !pready_o && bad
        |=> pslverr_o && prdata_o == 32'h0) else $error("bad address accepted");
endmodule : rri_checker
bind rri_reset_register_init rri_checker u_chk (.clk_i, .sys_rst_i, .cause_i,
    .supply_low_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .pc_o, .gie_o, .option_o, .port_dir_o);
`default_nettype wire

// ---- test/rri_reset_register_init_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module rri_reset_register_init_tb_top;
    import rri_pkg::*;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, go = 1'b0, low = 1'b0, low_q;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic pready_o, pslverr_o, gie_o, err;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic [12:0] pc_o, port_dir_o;
    logic [7:0] option_o, sv, pl;
    logic [7:0] v [4];
    logic [1:0] tp;
    rri_cause_t want = 8'h00, cause;
    rri_event_t k;
    int fail_count = 0, checks = 0;
    logic [23:0] rt [9] = '{24'h02FF00, 24'h1F3F00, 24'h0A1F00, 24'h0C4000,
        24'h81FFFF, 24'h851F1F, 24'h86FFFF, 24'h8C4000, 24'h9FFF00};
    logic [7:0] pv [4] = '{8'hF0, 8'h01, 8'h04, 8'h06};

    rri_seq_model seq (.clk_i, .go_i(go), .low_i(low), .want_i(want),
        .cause_o(cause), .low_o(low_q));
    rri_reset_register_init dut (.clk_i, .sys_rst_i, .cause_i(cause),
        .supply_low_i(low_q), .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .pc_o, .gie_o, .option_o, .port_dir_o);

    initial
    begin
        forever #20 clk_i = ~clk_i;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (pready_o !== 1'b1 && n < 20);
        if (n >= 20)
            fail_count++;
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask : apb

    task automatic wr(input logic [7:0] ix, input logic [31:0] d);
        apb(1'b1, {2'b00, ix, 2'b00}, d);
    endtask : wr

    task automatic rchk(input logic [7:0] ix, input logic [7:0] m, input logic [7:0] e);
        apb(1'b0, {2'b00, ix, 2'b00}, 32'h0);
        chk($sformatf("reg %h", ix), {24'h0, e}, rd & {24'h0, m});
    endtask : rchk

    function automatic logic [1:0] topd(input rri_event_t kd, input logic [1:0] o);
        case (kd)
            EV_POWER_ON: return 2'b11;
            EV_MASTER_CLEAR_INPUT_SLEEP, EV_WAKE_IRQ: return 2'b10;
            EV_WDT_RESET: return {1'b0, o[0]};
            EV_WAKE_WDT: return 2'b00;
            default: return o;
        endcase
    endfunction : topd

    // event from sequencer after a prompt or slow start
    task automatic ev(input rri_event_t kd, input rri_wake_src_t s, input logic lo);
        repeat ($urandom_range(2)) @(posedge clk_i);
        want <= '{kind: kd, src: s};
        go <= 1'b1;
        low <= lo;
        @(posedge clk_i);
        go <= 1'b0;
        repeat (2) @(posedge clk_i);
        tp = lo ? 2'b11 : topd(kd, tp);
    endtask : ev

    task automatic tbl();
        for (int i = 0; i < 9; i++)
            rchk(rt[i][23:16], rt[i][15:8], rt[i][7:0]);
        chk("option_o", 32'hFF, {24'h0, option_o});
        chk("port_dir_o", 32'h1FFF, {19'h0, port_dir_o});
        chk("pc_o", 32'h0, {19'h0, pc_o});
        chk("gie_o", 32'h0, {31'h0, gie_o});
    endtask : tbl

    initial
    begin
        void'($urandom(32'hC1643130));
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        ev(EV_POWER_ON, 4'h0, 1'b0);
        tbl();
        rchk(IDX_CORE_STATUS, 8'hF8, 8'h18);
        rchk(IDX_POWER_FLAGS, 8'h02, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            k = rri_event_t'(2 + i % 4);
            for (int j = 0; j < 9; j++)
                wr(rt[j][23:16], $urandom);
            for (int j = 0; j < 4; j++)
            begin
                v[j] = 8'($urandom);
                wr(pv[j], {24'h0, v[j]});
            end
            sv = 8'($urandom);
            wr(IDX_CORE_STATUS, {24'h0, sv});
            wr(IDX_INT_CONTROL, {24'h0, sv});
            wr(IDX_POWER_FLAGS, 32'h3);
            ev(k, 4'h0, i == 7);
            tbl();
            rchk(IDX_CORE_STATUS, 8'hFF, {3'b000, tp, sv[2:0]});
            rchk(IDX_INT_CONTROL, 8'hFF, {7'h00, sv[0]});
            rchk(IDX_POWER_FLAGS, 8'h03, {6'h00, i != 7, k != EV_BROWN_OUT || i == 7});
            for (int j = 0; j < 4; j++)
                rchk(pv[j], 8'hFF, v[j]);
        end
        wr(IDX_INT_CONTROL, 32'h0);
        sv = 8'($urandom);
        pl = 8'($urandom_range(250));
        for (int j = 4; j < 9; j++)
            wr(rt[j][23:16], {24'h0, sv});
        wr(IDX_PC_LOW, {24'h0, pl});
        ev(EV_WAKE_WDT, 4'h0, 1'b0);
        chk("pc_o", {24'h0, pl + 8'd1}, {24'h0, pc_o[7:0]});
        chk("option_o", {24'h0, sv}, {24'h0, option_o});
        chk("port_dir_o", {19'h0, sv, sv[4:0]}, {19'h0, port_dir_o});
        rchk(IDX_CORE_STATUS, 8'h18, {3'b000, tp, 3'b000});
        ev(EV_WAKE_IRQ, 4'b0001, 1'b0);
        rchk(IDX_PERIPH_FLAGS, 8'h40, 8'h40);
        rchk(IDX_PC_LOW, 8'hFF, pl + 8'd2);
        rchk(IDX_VREF_CONTROL, 8'hFF, sv & 8'hEF);
        wr(IDX_INT_CONTROL, 32'h80);
        chk("gie_o", 32'h1, {31'h0, gie_o});
        ev(EV_WAKE_IRQ, 4'b1000, 1'b0);
        chk("pc_o", 32'h4, {19'h0, pc_o});
        rchk(IDX_INT_CONTROL, 8'h82, 8'h82);
        apb(1'b0, 12'h401, 32'h0);
        chk("pslverr_o", 32'h1, {31'h0, err});
        apb(1'b0, 12'h01C, 32'h0);
        chk("pslverr_o", 32'h1, {31'h0, err});
        results();
    end

    initial
    begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        results();
    end
endmodule : rri_reset_register_init_tb_top
`default_nettype wire

// ---- test/rri_seq_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rri_seq_model
    import rri_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       go_i,
    input  wire logic       low_i,
    input  wire rri_cause_t want_i,
    output rri_cause_t      cause_o,
    output logic            low_o
);
    // one encoded cause for one cycle, quiet otherwise
    always_ff @(posedge clk_i)
    begin
        cause_o <= go_i ? want_i : '{kind: EV_NONE, src: 4'h0};
        low_o   <= go_i & low_i;
    end
endmodule : rri_seq_model
`default_nettype wire
